/* File: pmu_irq_pkg.sv */
// shared constants, register map and carrier types of the pmu flag block
package pmu_irq_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int OV_DEGLITCH_NS = 8000;
	localparam int DEB_100US_NS = 100000;
	localparam int DEB_1MS_NS = 1000000;
	localparam int DEB_10MS_NS = 10000000;
	localparam int DEB_100MS_NS = 100000000;
	// least times round up to whole cycles
	localparam int OV_DEGLITCH_CYC =
		(OV_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_100US_CYC =
		(DEB_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_1MS_CYC =
		(DEB_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_10MS_CYC =
		(DEB_10MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_100MS_CYC =
		(DEB_100MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_W = 23;
	// register port widths and offsets
	localparam int DATA_W = 8;
	localparam logic [7:0] ADDR_EVT_LO = 8'h00;
	localparam logic [7:0] ADDR_EVT_HI = 8'h01;
	localparam logic [7:0] ADDR_EMASK_LO = 8'h02;
	localparam logic [7:0] ADDR_EMASK_HI = 8'h03;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_SMASK = 8'h05;
	localparam logic [7:0] ADDR_GPIO_TRIG = 8'h06;
	localparam logic [7:0] ADDR_GPIO_DEB = 8'h07;
	localparam logic [7:0] ADDR_IRQ_POL = 8'h08;
	// event flag positions
	localparam int NUM_EVT = 14;
	localparam int EV_TEMP_WARN = 0;
	localparam int EV_THERMAL_CRITICAL_FLAG = 1;
	localparam int EV_SG = 2;
	localparam int EV_PG1 = 3;
	localparam int EV_OV1 = 5;
	localparam int EV_UV1 = 7;
	localparam int EV_OC1 = 9;
	localparam int EV_GPIO0 = 11;
	localparam int NUM_GPIO = 3;
	localparam int NUM_BUCK = 2;
	// status bit positions and mask positions
	localparam int NUM_SMASK = 4;
	localparam int ST_PG1 = 0;
	localparam int ST_SG = 2;
	localparam int ST_WARN = 3;
	localparam int ST_CRIT = 4;
	// gpio trigger select codes
	localparam logic [1:0] TRIG_RISE = 2'h0;
	localparam logic [1:0] TRIG_FALL = 2'h1;
	localparam logic [1:0] TRIG_BOTH = 2'h2;
	// debounce select codes
	localparam logic [1:0] DEB_SEL_100US = 2'h0;
	localparam logic [1:0] DEB_SEL_1MS = 2'h1;
	localparam logic [1:0] DEB_SEL_10MS = 2'h2;
	// reset values
	localparam logic [NUM_EVT-1:0] EMASK_RST = 14'h0000;
	localparam logic [NUM_SMASK-1:0] SMASK_RST = 4'h0;
	localparam logic [5:0] GPIO_TRIG_RST = 6'h00;
	localparam logic [5:0] GPIO_DEB_RST = 6'h00;
	localparam logic POL_RST = 1'b0;
	// startup sequence states
	typedef enum logic [1:0] {
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10
	} init_st_t;
	// comparator and pin flags, normal level high except gpio
	typedef struct packed {
		logic temp_warn_n;
		logic thermal_critical_flag_n;
		logic sg;
		logic [1:0] pg;
		logic [1:0] ov_n;
		logic [1:0] uv_n;
		logic [1:0] oc_n;
		logic [2:0] gpio;
	} src_t;
	localparam int SRC_W = $bits(src_t);
	// one host register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

/* File: glitch_filter.sv */
// level filter: output follows input after it held steady for limit cycles
`timescale 1ns/1ps
module glitch_filter #(
	parameter int W = 23
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// control
	input wire logic clear,
	input wire logic [W-1:0] limit,
	// data
	input wire logic raw,
	output logic clean
);
	logic [W-1:0] cnt_ff;
	logic clean_ff;
	logic [W-1:0] nxt_cnt;
	logic nxt_clean;
	wire differ = raw != clean_ff;
	wire done = differ && (cnt_ff >= limit - W'(1));

	// counter restarts on any bounce, so both edges are filtered alike
	assign nxt_cnt = (clear || !differ || done) ? '0 : cnt_ff + W'(1);
	assign nxt_clean = clear ? 1'b0 : (done ? raw : clean_ff);
	assign clean = clean_ff;

	// state registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
			clean_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			clean_ff <= nxt_clean;
		end
	end
endmodule // glitch_filter

/* File: pmu_irq_flags.sv */
// interrupt, fault flag and chip enable logic of the dual buck pmu
`timescale 1ns/1ps
// Overview of operation
// - chip enable low powers logic down and pulls buck outputs down
// - fault events also change operation, such as disabling the bucks
// - thermal critical shuts both bucks down at once
// - over-voltage event, deglitched 8 us on rising and falling edges
// - under-voltage event with no deglitch delay
// - over-current event with no deglitch delay
// - power-good status reads 1 while output is inside its window
// - gpio change event on selected edge, debounce 100us/1ms/10ms/100ms
// - source flags except gpio are high when normal and low when abnormal
// - status interrupts follow live status, no clear needed
// - event flags are write-one-to-clear, 0 idle and 1 once event occurred
// - event flag and interrupt stay until host writes a clear or chip enable goes low
// - event mask 1 keeps event off interrupt, flag still updates
// - power-good status mask 1 blocks interrupt, status still tracks
// - system-good status reads 1 when good, mask blocks its interrupt
// - thermal warning status reads 1 while above warning threshold
// - thermal warning status mask blocks its interrupt only
// - status mask reset values come from otp set chosen by config pin
module pmu_irq_flags #(
	parameter int OV_CYC = pmu_irq_pkg::OV_DEGLITCH_CYC,
	parameter int DEB_100US_CYC = pmu_irq_pkg::DEB_100US_CYC,
	parameter int DEB_1MS_CYC = pmu_irq_pkg::DEB_1MS_CYC,
	parameter int DEB_10MS_CYC = pmu_irq_pkg::DEB_10MS_CYC,
	parameter int DEB_100MS_CYC = pmu_irq_pkg::DEB_100MS_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// pins and comparator flags
	input wire logic chip_enable_input,
	input wire logic config_select_pin,
	input wire pmu_irq_pkg::src_t src,
	// one-time-programmable settings
	input wire logic config_pin_select_enable,
	input wire logic [pmu_irq_pkg::NUM_SMASK-1:0] otp_smask_low,
	input wire logic [pmu_irq_pkg::NUM_SMASK-1:0] otp_smask_high,
	// host register port
	input wire pmu_irq_pkg::reg_req_t reg_req,
	output logic [pmu_irq_pkg::DATA_W-1:0] reg_rdata,
	// buck control
	output logic [pmu_irq_pkg::NUM_BUCK-1:0] buck_enable,
	output logic buck_pulldown,
	// interrupt pin
	output logic interrupt_output_pin
);
	localparam int FW = pmu_irq_pkg::FILT_W;
	localparam int NE = pmu_irq_pkg::NUM_EVT;
	localparam int NS = pmu_irq_pkg::NUM_SMASK;
	localparam int NG = pmu_irq_pkg::NUM_GPIO;
	localparam int NB = pmu_irq_pkg::NUM_BUCK;
	localparam int SW = pmu_irq_pkg::SRC_W + 2;

	logic [SW-1:0] meta_ff, sync_ff;
	logic [NE-1:0] cond_prev_ff, evt_ff, emask_ff;
	logic [NS-1:0] smask_ff;
	logic [5:0] trig_ff, deb_ff;
	logic pol_ff, pin_ff, pulldown_ff;
	logic [NB-1:0] buck_run_ff;
	logic [7:0] rdata_ff;
	pmu_irq_pkg::init_st_t state_ff, nxt_state;
	logic [NE-1:0] nxt_evt, nxt_emask;
	logic [NS-1:0] nxt_smask;

	// every pin passes two flops; only sync_ff is read by logic
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= {chip_enable_input, config_select_pin, src};
			sync_ff <= meta_ff;
		end
	end

	wire en = sync_ff[SW-1];
	wire config_select_pin_lvl = sync_ff[SW-2];
	pmu_irq_pkg::src_t s;
	assign s = pmu_irq_pkg::src_t'(sync_ff[SW-3:0]);

	// over-voltage deglitch on both edges
	wire [NB-1:0] ov_clean;
	genvar gi;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_ov
			glitch_filter #(.W(FW)) u_ov (
				.mclk(mclk),
				.arst_n(arst_n),
				.clear(!en),
				.limit(FW'(OV_CYC)),
				.raw(!s.ov_n[gi]),
				.clean(ov_clean[gi])
			);
		end
	endgenerate

	// gpio debounce with per-pin period select
	wire [NG-1:0] gpio_clean;
	generate
		for (gi = 0; gi < NG; gi++) begin : g_gpio
			wire [1:0] sel = deb_ff[2*gi +: 2];
			wire [FW-1:0] lim =
				(sel == pmu_irq_pkg::DEB_SEL_100US) ? FW'(DEB_100US_CYC) :
				(sel == pmu_irq_pkg::DEB_SEL_1MS) ? FW'(DEB_1MS_CYC) :
				(sel == pmu_irq_pkg::DEB_SEL_10MS) ? FW'(DEB_10MS_CYC) :
				FW'(DEB_100MS_CYC);
			glitch_filter #(.W(FW)) u_deb (
				.mclk(mclk),
				.arst_n(arst_n),
				.clear(!en),
				.limit(lim),
				.raw(s.gpio[gi]),
				.clean(gpio_clean[gi])
			);
		end
	endgenerate

	// event conditions, high while the event's trigger state holds
	wire [NE-1:0] cond = {gpio_clean, ~s.oc_n, ~s.uv_n, ov_clean,
		s.pg, s.sg, ~s.thermal_critical_flag_n, ~s.temp_warn_n};
	wire [NE-1:0] rise = cond & ~cond_prev_ff;
	wire [NE-1:0] fall = ~cond & cond_prev_ff;

	// gpio edges pass only when the trigger select allows them
	wire [NG-1:0] gpio_set;
	generate
		for (gi = 0; gi < NG; gi++) begin : g_trig
			localparam int EI = pmu_irq_pkg::EV_GPIO0 + gi;
			wire [1:0] t = trig_ff[2*gi +: 2];
			assign gpio_set[gi] =
				(t == pmu_irq_pkg::TRIG_RISE) ? rise[EI] :
				(t == pmu_irq_pkg::TRIG_FALL) ? fall[EI] :
				(t == pmu_irq_pkg::TRIG_BOTH) ? (rise[EI] | fall[EI]) :
				1'b0;
		end
	endgenerate
	// sync chain resets to zero and set_vec waits for running, so no edge counts before run
	wire running = en && (state_ff == pmu_irq_pkg::ST_RUN);
	localparam int EG = pmu_irq_pkg::EV_GPIO0;
	wire [NE-1:0] set_vec = running ? {gpio_set, rise[EG-1:0]} : '0;

	// register decode
	wire wr = reg_req.wr && running;
	wire [7:0] a = reg_req.addr;
	wire [7:0] d = reg_req.wdata;
	wire wr_elo = wr && (a == pmu_irq_pkg::ADDR_EVT_LO);
	wire wr_ehi = wr && (a == pmu_irq_pkg::ADDR_EVT_HI);
	wire wr_mlo = wr && (a == pmu_irq_pkg::ADDR_EMASK_LO);
	wire wr_mhi = wr && (a == pmu_irq_pkg::ADDR_EMASK_HI);
	wire wr_sm = wr && (a == pmu_irq_pkg::ADDR_SMASK);
	wire wr_trig = wr && (a == pmu_irq_pkg::ADDR_GPIO_TRIG);
	wire wr_deb = wr && (a == pmu_irq_pkg::ADDR_GPIO_DEB);
	wire wr_pol = wr && (a == pmu_irq_pkg::ADDR_IRQ_POL);
	wire [15:0] clr16 = {wr_ehi ? d : 8'h00, wr_elo ? d : 8'h00};
	wire [NE-1:0] clr_vec = clr16[NE-1:0];

	// write one clears; a new event in the same cycle wins over the clear
	assign nxt_evt = en ? ((evt_ff & ~clr_vec) | set_vec) : '0;
	wire [15:0] em16 = {2'b00, emask_ff};
	wire [15:0] em_new = {wr_mhi ? d : em16[15:8], wr_mlo ? d : em16[7:0]};
	assign nxt_emask = en ? em_new[NE-1:0] : pmu_irq_pkg::EMASK_RST;

	// status mask loads from the otp set at power-up, then host owns it
	wire [NS-1:0] smask_boot = !config_pin_select_enable ?
		pmu_irq_pkg::SMASK_RST :
		(config_select_pin_lvl ? otp_smask_high : otp_smask_low);
	always_comb begin
		nxt_state = state_ff;
		nxt_smask = smask_ff;
		unique case (state_ff)
			pmu_irq_pkg::ST_LOAD: begin
				if (en) begin
					nxt_smask = smask_boot;
					nxt_state = pmu_irq_pkg::ST_RUN;
				end
			end
			pmu_irq_pkg::ST_RUN: begin
				if (!en)
					nxt_state = pmu_irq_pkg::ST_LOAD;
				else if (wr_sm)
					nxt_smask = d[NS-1:0];
			end
			default: nxt_state = pmu_irq_pkg::ST_LOAD;
		endcase
	end

	// live status and its interrupting levels
	wire [4:0] status = {~s.thermal_critical_flag_n, ~s.temp_warn_n, s.sg, s.pg};
	wire [NS-1:0] stat_irq = {~s.temp_warn_n, ~s.sg, ~s.pg};
	wire evt_irq = |(evt_ff & ~emask_ff);
	wire st_irq = |(stat_irq & ~smask_ff);
	wire irq_any = en && (evt_irq || st_irq);

	// read mux; unmapped offsets read zero
	wire [15:0] ev16 = {2'b00, evt_ff};
	wire [7:0] rd_val =
		(a == pmu_irq_pkg::ADDR_EVT_LO) ? ev16[7:0] :
		(a == pmu_irq_pkg::ADDR_EVT_HI) ? ev16[15:8] :
		(a == pmu_irq_pkg::ADDR_EMASK_LO) ? em16[7:0] :
		(a == pmu_irq_pkg::ADDR_EMASK_HI) ? em16[15:8] :
		(a == pmu_irq_pkg::ADDR_STATUS) ? {3'b000, status} :
		(a == pmu_irq_pkg::ADDR_SMASK) ? {4'h0, smask_ff} :
		(a == pmu_irq_pkg::ADDR_GPIO_TRIG) ? {2'b00, trig_ff} :
		(a == pmu_irq_pkg::ADDR_GPIO_DEB) ? {2'b00, deb_ff} :
		(a == pmu_irq_pkg::ADDR_IRQ_POL) ? {7'h00, pol_ff} : 8'h00;

	// thermal critical or its pending fault flag holds both bucks off
	wire crit_fault = !s.thermal_critical_flag_n || evt_ff[pmu_irq_pkg::EV_THERMAL_CRITICAL_FLAG];
	wire run_ok = en && !crit_fault;

	// flag, mask and output registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= pmu_irq_pkg::ST_LOAD;
			cond_prev_ff <= '0;
			evt_ff <= '0;
			emask_ff <= pmu_irq_pkg::EMASK_RST;
			smask_ff <= pmu_irq_pkg::SMASK_RST;
			trig_ff <= pmu_irq_pkg::GPIO_TRIG_RST;
			deb_ff <= pmu_irq_pkg::GPIO_DEB_RST;
			pol_ff <= pmu_irq_pkg::POL_RST;
			pin_ff <= 1'b0;
			pulldown_ff <= 1'b1;
			buck_run_ff <= '0;
			rdata_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			cond_prev_ff <= cond;
			evt_ff <= nxt_evt;
			emask_ff <= nxt_emask;
			smask_ff <= nxt_smask;
			trig_ff <= !en ? pmu_irq_pkg::GPIO_TRIG_RST :
				(wr_trig ? d[5:0] : trig_ff);
			deb_ff <= !en ? pmu_irq_pkg::GPIO_DEB_RST :
				(wr_deb ? d[5:0] : deb_ff);
			pol_ff <= !en ? pmu_irq_pkg::POL_RST : (wr_pol ? d[0] : pol_ff);
			pin_ff <= irq_any ^ pol_ff;
			pulldown_ff <= !en;
			buck_run_ff <= {NB{run_ok}};
			rdata_ff <= reg_req.rd ? rd_val : rdata_ff;
		end
	end

	assign reg_rdata = rdata_ff;
	assign buck_enable = buck_run_ff;
	assign buck_pulldown = pulldown_ff;
	assign interrupt_output_pin = pin_ff;

	// helper: length of the current raw over-voltage run on buck 1
	logic [15:0] ov_run_ff;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			ov_run_ff <= 16'h0000;
		else
			ov_run_ff <= s.ov_n[0] ? 16'h0000 : ov_run_ff + 16'h0001;
	end

	sequence s_crit_seen;
		!s.thermal_critical_flag_n;
	endsequence
	sequence s_bucks_off;
		buck_run_ff == '0;
	endsequence

	wire buck_pulldown_chk = pulldown_ff && (buck_run_ff == '0);
	property p_power_down;
		@(posedge mclk) disable iff (!arst_n)
		!en |=> buck_pulldown_chk;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("chip disabled but bucks not pulled down");

	property p_crit_off;
		@(posedge mclk) disable iff (!arst_n)
		s_crit_seen |=> s_bucks_off;
	endproperty
	a_crit_off: assert property (p_crit_off)
		else $error("bucks still enabled during thermal critical");

	property p_ov_deglitch;
		@(posedge mclk) disable iff (!arst_n || !en)
		$rose(ov_clean[0]) |-> ($past(ov_run_ff) >= 16'(OV_CYC - 1));
	endproperty
	a_ov_deglitch: assert property (p_ov_deglitch)
		else $error("over-voltage passed before deglitch time");

	property p_uv_fast;
		@(posedge mclk) disable iff (!arst_n || !running)
		$fell(s.uv_n[0]) |=> evt_ff[pmu_irq_pkg::EV_UV1];
	endproperty
	a_uv_fast: assert property (p_uv_fast)
		else $error("under-voltage flag not set next cycle");

	property p_oc_fast;
		@(posedge mclk) disable iff (!arst_n || !running)
		$fell(s.oc_n[0]) |=> evt_ff[pmu_irq_pkg::EV_OC1];
	endproperty
	a_oc_fast: assert property (p_oc_fast)
		else $error("over-current flag not set next cycle");

	property p_pg_read;
		@(posedge mclk) disable iff (!arst_n)
		reg_req.rd && (a == pmu_irq_pkg::ADDR_STATUS)
		|=> rdata_ff[pmu_irq_pkg::ST_PG1] == $past(s.pg[0]);
	endproperty
	a_pg_read: assert property (p_pg_read)
		else $error("power-good status read mismatch");

	property p_flag_hold;
		@(posedge mclk) disable iff (!arst_n || !en)
		1'b1 |=> ((evt_ff & $past(evt_ff & ~clr_vec))
			== $past(evt_ff & ~clr_vec));
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("event flag dropped without a host clear");

	property p_irq_idle;
		@(posedge mclk) disable iff (!arst_n)
		!irq_any |=> interrupt_output_pin == $past(pol_ff);
	endproperty
	a_irq_idle: assert property (p_irq_idle)
		else $error("interrupt active with nothing unmasked");

	property p_irq_on;
		@(posedge mclk) disable iff (!arst_n)
		irq_any |=> interrupt_output_pin != $past(pol_ff);
	endproperty
	a_irq_on: assert property (p_irq_on)
		else $error("interrupt not driven at its active level");

	property p_boot_mask;
		@(posedge mclk) disable iff (!arst_n)
		(state_ff == pmu_irq_pkg::ST_LOAD) && en
		|=> smask_ff == $past(smask_boot);
	endproperty
	a_boot_mask: assert property (p_boot_mask)
		else $error("status mask not loaded from otp set");
endmodule // pmu_irq_flags

/* File: host_model.sv */
// host processor model: register port accesses for the pmu flag block
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic mclk,
	// register port
	output pmu_irq_pkg::reg_req_t reg_req,
	input wire logic [7:0] reg_rdata
);
	initial reg_req = '0;

	// one write, held across exactly one rising edge
	// a write of ones to a flag register clears those flags
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge mclk);
		// released lines show garbage, not the last value
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// one read, data is registered at the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge mclk);
		d = reg_rdata;
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
	endtask
endmodule // host_model

/* File: pmu_irq_flags_tb.sv */
// self-checking testbench of the pmu interrupt and fault flag block
`timescale 1ns/1ps
module pmu_irq_flags_tb;
	// all sources in their normal state, gpio pins low
	localparam pmu_irq_pkg::src_t NORM = 14'h3FF8;
	logic mclk, arst_n, chip_en, cfg_pin, cfg_sel_en, buck_pd, irq;
	logic [3:0] otp_lo, otp_hi;
	logic [1:0] buck_en;
	logic [7:0] reg_rdata;
	pmu_irq_pkg::src_t src;
	pmu_irq_pkg::reg_req_t reg_req;
	int fails = 0;
	int n_compared = 0;

	// short counts keep the deglitch and debounce runs brief
	pmu_irq_flags #(.OV_CYC(8), .DEB_100US_CYC(5), .DEB_1MS_CYC(8),
		.DEB_10MS_CYC(11), .DEB_100MS_CYC(14)) pmu_irq_flags_i (
		.mclk(mclk), .arst_n(arst_n), .chip_enable_input(chip_en),
		.config_select_pin(cfg_pin), .src(src),
		.config_pin_select_enable(cfg_sel_en), .otp_smask_low(otp_lo),
		.otp_smask_high(otp_hi), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.buck_enable(buck_en), .buck_pulldown(buck_pd),
		.interrupt_output_pin(irq));
	host_model host_model_i (.mclk(mclk), .reg_req(reg_req),
		.reg_rdata(reg_rdata));

	always #12.5 mclk = ~mclk;

	// comparisons of bytes and of single bits
	task automatic chk8(input logic [7:0] g, input logic [7:0] e, string m);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e, input string m);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %s got %b exp %b", $time, m, g, e);
		end
	endtask
	task automatic rdx(input logic [7:0] a, input logic [7:0] e, string m);
		logic [7:0] v;
		host_model_i.rd(a, v);
		chk8(v, e, m);
	endtask
	// clear every event flag, then let the pin settle
	task automatic clr;
		host_model_i.wr(pmu_irq_pkg::ADDR_EVT_LO, 8'hFF);
		host_model_i.wr(pmu_irq_pkg::ADDR_EVT_HI, 8'hFF);
		repeat (3) @(negedge mclk);
	endtask
	// pulse one source, read its flag after the source is back to normal
	task automatic ev_case(input pmu_irq_pkg::src_t bad, input int b,
		input int hold, input logic fe, input logic ie);
		logic [15:0] e;
		e = {15'h0, fe} << b;
		src = bad;
		repeat (hold) @(negedge mclk);
		src = NORM;
		repeat (12) @(negedge mclk);
		rdx(pmu_irq_pkg::ADDR_EVT_LO, e[7:0], "event low");
		rdx(pmu_irq_pkg::ADDR_EVT_HI, e[15:8], "event high");
		chk1(irq, ie, "irq from event");
		clr();
		chk1(irq, 1'b0, "irq after clear");
	endtask

	// mask reload from the selected otp set, chip enable power down
	task automatic t_cfg;
		clr();
		rdx(pmu_irq_pkg::ADDR_SMASK, 8'h05, "smask set low");
		chk1(buck_pd, 1'b0, "pulldown off");
		chip_en = 1'b0;
		cfg_pin = 1'b1;
		repeat (6) @(negedge mclk);
		chk1(buck_pd, 1'b1, "pulldown on");
		chk8({6'h0, buck_en}, 8'h00, "bucks off");
		chip_en = 1'b1;
		repeat (8) @(negedge mclk);
		rdx(pmu_irq_pkg::ADDR_SMASK, 8'h0A, "smask set high");
		// with pin selection off the masks come up at their reset value
		cfg_sel_en = 1'b0;
		chip_en = 1'b0;
		repeat (6) @(negedge mclk);
		chip_en = 1'b1;
		repeat (8) @(negedge mclk);
		rdx(pmu_irq_pkg::ADDR_SMASK, 8'h00, "smask default");
		clr();
		chk8({6'h0, buck_en}, 8'h03, "bucks on");
		chk1(irq, 1'b0, "idle irq");
	endtask
	// every event source, then an over-voltage glitch and a masked event
	task automatic t_events;
		int sb [14] = '{13, 12, 11, 9, 10, 7, 8, 5, 6, 3, 4, 0, 1, 2};
		for (int b = 0; b < 14; b++)
			ev_case(NORM ^ (14'h1 << sb[b]), b, 20, 1'b1, 1'b1);
		ev_case(NORM ^ 14'h0080, 5, 4, 1'b0, 1'b0);
		host_model_i.wr(pmu_irq_pkg::ADDR_EMASK_LO, 8'h80);
		ev_case(NORM ^ 14'h0020, 7, 4, 1'b1, 1'b0);
		host_model_i.wr(pmu_irq_pkg::ADDR_EMASK_LO, 8'h00);
	endtask
	// thermal critical stops both bucks until its flag is cleared
	task automatic t_buck;
		src = NORM ^ 14'h1000;
		repeat (6) @(negedge mclk);
		chk8({6'h0, buck_en}, 8'h00, "crit stop");
		src = NORM;
		repeat (6) @(negedge mclk);
		chk8({6'h0, buck_en}, 8'h00, "crit held");
		clr();
		chk8({6'h0, buck_en}, 8'h03, "crit cleared");
	endtask
	// live status sources: pg1, pg2, sg, warn, each masked in turn
	task automatic t_status;
		logic [7:0] v;
		int sb [4] = '{9, 10, 11, 13};
		host_model_i.wr(pmu_irq_pkg::ADDR_EMASK_LO, 8'h1D);
		for (int i = 0; i < 4; i++) begin
			src = NORM ^ (14'h1 << sb[i]);
			repeat (6) @(negedge mclk);
			host_model_i.rd(pmu_irq_pkg::ADDR_STATUS, v);
			chk8(v, 8'h07 ^ (8'h01 << i), "status");
			chk1(irq, 1'b1, "status irq");
			host_model_i.wr(pmu_irq_pkg::ADDR_SMASK, 8'h01 << i);
			repeat (3) @(negedge mclk);
			chk1(irq, 1'b0, "status masked");
			host_model_i.rd(pmu_irq_pkg::ADDR_STATUS, v);
			chk8(v, 8'h07 ^ (8'h01 << i), "masked status");
			src = NORM;
			repeat (6) @(negedge mclk);
			host_model_i.wr(pmu_irq_pkg::ADDR_SMASK, 8'h00);
			repeat (3) @(negedge mclk);
			chk1(irq, 1'b0, "status gone");
		end
		clr();
		host_model_i.wr(pmu_irq_pkg::ADDR_EMASK_LO, 8'h00);
	endtask
	// set the gpio0 level, wait, and compare its change flag
	task automatic gpio_case(input logic lvl, input int w, input logic e);
		src.gpio[0] = lvl;
		repeat (w) @(negedge mclk);
		rdx(pmu_irq_pkg::ADDR_EVT_HI, {4'h0, e, 3'h0}, "gpio flag");
	endtask
	// all trigger codes, then each longer debounce
	task automatic t_gpio;
		for (int c = 0; c < 4; c++) begin
			host_model_i.wr(pmu_irq_pkg::ADDR_GPIO_TRIG, 8'(c));
			gpio_case(1'b1, 24, c == 0 || c == 2);
			clr();
			gpio_case(1'b0, 24, c == 1 || c == 2);
			clr();
		end
		host_model_i.wr(pmu_irq_pkg::ADDR_GPIO_TRIG, 8'h00);
		// just short of each longer debounce, then well past it
		for (int k = 1; k < 4; k++) begin
			host_model_i.wr(pmu_irq_pkg::ADDR_GPIO_DEB, 8'(k));
			gpio_case(1'b1, 4 + 3 * k, 1'b0);
			gpio_case(1'b1, 14, 1'b1);
			clr();
			gpio_case(1'b0, 24, 1'b0);
		end
		host_model_i.wr(pmu_irq_pkg::ADDR_GPIO_DEB, 8'h00);
	endtask
	// pin polarity, plus an unmapped read
	task automatic t_pol;
		src = NORM ^ 14'h0008;
		repeat (4) @(negedge mclk);
		src = NORM;
		repeat (6) @(negedge mclk);
		chk1(irq, 1'b1, "active high");
		host_model_i.wr(pmu_irq_pkg::ADDR_IRQ_POL, 8'h01);
		repeat (3) @(negedge mclk);
		chk1(irq, 1'b0, "active low set");
		clr();
		chk1(irq, 1'b1, "active low idle");
		host_model_i.wr(pmu_irq_pkg::ADDR_IRQ_POL, 8'h00);
		repeat (3) @(negedge mclk);
		chk1(irq, 1'b0, "high idle");
		rdx(8'h20, 8'h00, "unmapped");
	endtask

	task automatic give_verdict;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog, several times the expected run length
	initial begin
		#300us;
		fails++;
		give_verdict();
	end

	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		chip_en = 1'b1;
		cfg_pin = 1'b0;
		cfg_sel_en = 1'b1;
		otp_lo = 4'h5;
		otp_hi = 4'hA;
		src = NORM;
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		repeat (8) @(negedge mclk);
		t_cfg();
		t_events();
		t_buck();
		t_status();
		t_gpio();
		t_pol();
		give_verdict();
	end
endmodule // pmu_irq_flags_tb
